// >>> pfs_pkg.sv
// Package: constants and carrier types for the pad function select block
package pfs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] PFS_OFF_PAD_CFG_BASE = 12'h000;  // pad_config_reg[i] at base + 4*i
  localparam logic [11:0] PFS_OFF_SRC_SEL_BASE = 12'h400;  // input_source_sel_reg[j]
  localparam logic [11:0] PFS_OFF_USER_OPT     = 12'h800;  // user_option_word
  localparam logic [11:0] PFS_OFF_STATUS       = 12'h804;  // block status
  localparam logic [11:0] PFS_OFF_DEV_PORT     = 12'h808;  // dev_port_interface control

  // pad_config_reg fields
  localparam int PFS_PCR_FUNC_LSB   = 0;   // pad_function_field, 3 bits
  localparam int PFS_PCR_FUNC_W     = 3;
  localparam int PFS_PCR_OBE_BIT    = 8;   // output_buffer_en
  localparam int PFS_PCR_IBE_BIT    = 9;   // input_buffer_en
  localparam int PFS_PCR_PUE_BIT    = 10;  // pullup_en
  localparam int PFS_PCR_NMI_BIT    = 12;  // pad used as nonmaskable interrupt input

  // user_option_word fields
  localparam int PFS_OPT_SUPPLY_A_BIT = 0;  // supply_level_sel domain A
  localparam int PFS_OPT_SUPPLY_B_BIT = 1;  // supply_level_sel domain B

  // dev_port_interface control fields
  localparam int PFS_DPC_TCLK_EN_BIT = 0;  // trace_clk_enable
  localparam int PFS_DPC_PSTAT_BIT   = 1;  // proc_status_enable
  localparam int PFS_DPC_FPM_BIT     = 2;  // full_port_mode

  // Reset and delivery values
  localparam logic [2:0] PFS_FUNC_FIRST  = 3'h0;  // alt_func_first (general-purpose path)
  localparam logic [2:0] PFS_FUNC_FIFTH  = 3'h4;  // alt_func_fifth
  localparam logic [1:0] PFS_SUPPLY_DELIVERED = 2'h3;
  localparam logic       PFS_SUPPLY_5V0 = 1'b0;

  // Supply settle time before pads leave input state
  localparam int PFS_SETTLE_NS     = 1000;
  localparam int PFS_CLK_PERIOD_NS = 8;
  localparam int PFS_SETTLE_CYC    = (PFS_SETTLE_NS + PFS_CLK_PERIOD_NS - 1) / PFS_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PFS_ST_POWERUP = 3'b001,
    PFS_ST_RESET   = 3'b010,
    PFS_ST_RUN     = 3'b100
  } pfs_state_t;

  typedef struct packed {
    logic [2:0] func;
    logic       output_buffer_en;
    logic       input_buffer_en;
    logic       pullup_en;
    logic       nmi;
  } pfs_pad_cfg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pfs_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pfs_apb_rsp_t;

endpackage : pfs_pkg

// >>> pfs_top.sv
// Top: pad function select with APB configuration registers
`timescale 1ns/100ps
module pfs_top #(
  parameter int NUM_PADS  = 16,
  parameter int NUM_SEL   = 4,
  parameter int SEL_W     = 4,
  parameter int JTAG_TDI  = 0,
  parameter int JTAG_TDO  = 1,
  parameter int JTAG_TCK  = 2,
  parameter int JTAG_TMS  = 3,
  parameter int SETTLE_CYC = pfs_pkg::PFS_SETTLE_CYC
) (
  input  wire logic                  clock_in,            // System clock
  input  wire logic                  rst_n_in,            // Sync reset, active low
  input  wire pfs_pkg::pfs_apb_req_t apb_in,              // APB request
  output pfs_pkg::pfs_apb_rsp_t      apb_out,             // APB answer
  input  wire logic [NUM_PADS*5-1:0] alt_out_in,          // Five alternate outputs per pad
  input  wire logic [NUM_PADS*5-1:0] alt_oe_in,           // Their enables
  input  wire logic [NUM_PADS-1:0]   gpio_out_in,         // General-purpose output data
  input  wire logic [NUM_PADS-1:0]   pad_in,              // Pad input level
  output logic      [NUM_PADS-1:0]   pad_out,             // Pad output level
  output logic      [NUM_PADS-1:0]   pad_oe_out,          // Pad output enable
  output logic      [NUM_PADS-1:0]   pad_pullup_out,      // Pad weak pull-up
  output logic      [NUM_PADS-1:0]   periph_in_out,       // Gated inputs, fanned to all users
  output logic      [NUM_SEL-1:0]    sel_in_out,          // Selected shared peripheral inputs
  output logic      [1:0]            nmi_out,             // Nonmaskable interrupt inputs
  output logic      [3:0]            jtag_in_out,         // Debug inputs: tdi, tck, tms, unused
  input  wire logic                  jtag_tdo_in,         // Debug data out
  input  wire logic                  memory_selftest_en_in,         // Self-test controller enable
  input  wire logic [11:0]           trace_data_in,       // Trace data from debug logic
  input  wire logic                  trace_clk_in,        // Trace clock from debug logic
  input  wire logic                  trace_trace_msg_seq_out_in,       // Message sequence from debug logic
  output logic      [11:0]           trace_data_out,      // Trace data pads
  output logic      [11:0]           trace_data_oe_out,   // Trace data pad enables
  output logic                       trace_clock_out,     // Trace clock pad
  output logic                       trace_msg_seq_out,   // Message sequence pad
  output logic                       trace_port_oe_out,   // Enable for clock and sequence pads
  output logic      [1:0]            supply_level_sel_out,// Per-domain supply level
  input  wire logic                  supply_ok_in         // Supply level is final
);
  import pfs_pkg::*;

  initial begin
    if (NUM_PADS < 5 || NUM_PADS > 256 || NUM_SEL < 1 || NUM_SEL > 64 || (1 << SEL_W) < NUM_PADS)
      $error("pfs_top: unsupported parameters");
  end

  typedef struct packed {
    pfs_state_t                  st;
    logic [15:0]                 settle;
    pfs_pad_cfg_t [NUM_PADS-1:0] cfg;
    logic [NUM_SEL-1:0][SEL_W-1:0] src;
    logic [1:0]                  supply;
    logic [2:0]                  dpc;
    logic [NUM_PADS-1:0]         po;
    logic [NUM_PADS-1:0]         poe;
    logic [NUM_PADS-1:0]         ppu;
    logic [NUM_PADS-1:0]         pin;
    logic [NUM_SEL-1:0]          sin;
    logic [11:0]                 tdo;
    logic [11:0]                 toe;
    logic [31:0]                 rdata;
  } pfs_regs_t;

  pfs_regs_t r;
  pfs_regs_t next_r;

  logic        wr_acc;
  logic        rd_acc;
  logic [9:0]  idx;
  logic        hit_cfg;
  logic        hit_src;
  logic [2:0]  fsel;
  logic        run;
  logic        low_en;
  logic        high_en;

  assign wr_acc  = apb_in.psel && apb_in.penable && apb_in.pwrite;
  assign rd_acc  = apb_in.psel && !apb_in.penable && !apb_in.pwrite;
  assign idx     = apb_in.paddr[11:2];
  assign hit_cfg = apb_in.paddr < PFS_OFF_SRC_SEL_BASE && int'(idx) < NUM_PADS;
  assign hit_src = apb_in.paddr >= PFS_OFF_SRC_SEL_BASE && apb_in.paddr < PFS_OFF_USER_OPT
                   && int'(idx - PFS_OFF_SRC_SEL_BASE[11:2]) < NUM_SEL;

  always_comb begin
    next_r = r;
    fsel   = PFS_FUNC_FIRST;
    run    = 1'b0;
    // ****************************************
    // Power-up and reset sequencing
    // ****************************************
    case (r.st)
      PFS_ST_POWERUP: begin
        if (!supply_ok_in)
          next_r.settle = '0;
        else if (int'(r.settle) >= SETTLE_CYC - 1)
          next_r.st = PFS_ST_RUN;
        else
          next_r.settle = r.settle + 16'h0001;
      end
      PFS_ST_RESET: next_r.st = PFS_ST_RUN;
      PFS_ST_RUN:   run = 1'b1;
      default:      next_r.st = PFS_ST_POWERUP;
    endcase

    // ****************************************
    // Register writes
    // ****************************************
    if (wr_acc) begin
      if (hit_cfg) begin
        next_r.cfg[idx].func = apb_in.pwdata[PFS_PCR_FUNC_LSB +: PFS_PCR_FUNC_W];
        next_r.cfg[idx].output_buffer_en  = apb_in.pwdata[PFS_PCR_OBE_BIT];
        next_r.cfg[idx].input_buffer_en  = apb_in.pwdata[PFS_PCR_IBE_BIT];
        next_r.cfg[idx].pullup_en  = apb_in.pwdata[PFS_PCR_PUE_BIT];
        next_r.cfg[idx].nmi  = apb_in.pwdata[PFS_PCR_NMI_BIT];
      end
      if (hit_src)
        next_r.src[idx - PFS_OFF_SRC_SEL_BASE[11:2]] = apb_in.pwdata[SEL_W-1:0];
      if (apb_in.paddr == PFS_OFF_USER_OPT)
        next_r.supply = apb_in.pwdata[1:0];
      if (apb_in.paddr == PFS_OFF_DEV_PORT && !run)
        next_r.dpc = apb_in.pwdata[2:0];
    end

    // Read data captured in setup so it stands through the access phase
    if (rd_acc) begin
      next_r.rdata = '0;
      if (hit_cfg) begin
        next_r.rdata[PFS_PCR_FUNC_LSB +: PFS_PCR_FUNC_W] = r.cfg[idx].func;
        next_r.rdata[PFS_PCR_OBE_BIT] = r.cfg[idx].output_buffer_en;
        next_r.rdata[PFS_PCR_IBE_BIT] = r.cfg[idx].input_buffer_en;
        next_r.rdata[PFS_PCR_PUE_BIT] = r.cfg[idx].pullup_en;
        next_r.rdata[PFS_PCR_NMI_BIT] = r.cfg[idx].nmi;
      end else if (hit_src)
        next_r.rdata[SEL_W-1:0] = r.src[idx - PFS_OFF_SRC_SEL_BASE[11:2]];
      else if (apb_in.paddr == PFS_OFF_USER_OPT)
        next_r.rdata[1:0] = r.supply;
      else if (apb_in.paddr == PFS_OFF_STATUS)
        next_r.rdata[4:0] = {memory_selftest_en_in, supply_ok_in, r.st};
      else if (apb_in.paddr == PFS_OFF_DEV_PORT)
        next_r.rdata[2:0] = r.dpc;
    end

    // ****************************************
    // Pad output routing
    // ****************************************
    for (int i = 0; i < NUM_PADS; i++) begin
      fsel = r.cfg[i].func;
      next_r.ppu[i] = r.cfg[i].pullup_en;
      if (!run || r.cfg[i].nmi) begin
        next_r.poe[i] = 1'b0;
        next_r.po[i]  = 1'b0;
      end else if (fsel <= PFS_FUNC_FIFTH) begin
        next_r.po[i]  = (fsel == PFS_FUNC_FIRST) ? gpio_out_in[i] : alt_out_in[i*5 + int'(fsel)];
        next_r.poe[i] = (fsel == PFS_FUNC_FIRST) ? r.cfg[i].output_buffer_en : alt_oe_in[i*5 + int'(fsel)];
      end else begin
        next_r.po[i]  = gpio_out_in[i];
        next_r.poe[i] = r.cfg[i].output_buffer_en;
      end
      if (i == JTAG_TDO && run && r.cfg[i].func == PFS_FUNC_FIRST && !r.cfg[i].output_buffer_en) begin
        next_r.po[i]  = jtag_tdo_in;
        next_r.poe[i] = 1'b1;
      end
      next_r.pin[i] = pad_in[i] & r.cfg[i].input_buffer_en;
    end
    for (int j = 0; j < NUM_SEL; j++)
      next_r.sin[j] = next_r.pin[r.src[j]];

    // ****************************************
    // Trace port
    // ****************************************
    low_en  = r.dpc[PFS_DPC_TCLK_EN_BIT] | r.dpc[PFS_DPC_PSTAT_BIT];
    high_en = (r.dpc[PFS_DPC_TCLK_EN_BIT] & r.dpc[PFS_DPC_FPM_BIT])
              | r.dpc[PFS_DPC_PSTAT_BIT];
    next_r.tdo = trace_data_in;
    next_r.toe = {{4{high_en}}, {8{low_en}}};
    if (!run && memory_selftest_en_in) begin
      next_r.tdo[0] = 1'b1;
      next_r.toe[0] = 1'b1;
    end else if (!low_en)
      next_r.toe[0] = 1'b0;

    if (!rst_n_in) begin
      next_r       = '0;
      next_r.st     = PFS_ST_POWERUP;
      next_r.settle = '0;
      next_r.supply = PFS_SUPPLY_DELIVERED;
      // Unknown or power-up state takes the delivered values
      if (r.st == PFS_ST_RUN || r.st == PFS_ST_RESET) begin
        next_r.st     = PFS_ST_RESET;
        next_r.supply = r.supply;
        next_r.dpc    = r.dpc;
      end
      for (int i = 0; i < NUM_PADS; i++) begin
        next_r.cfg[i].func = PFS_FUNC_FIRST;
        next_r.cfg[i].input_buffer_en  = (i == JTAG_TDI || i == JTAG_TCK || i == JTAG_TMS);
        next_r.cfg[i].pullup_en  = (i == JTAG_TCK || i == JTAG_TMS);
      end
    end
  end

  always_ff @(posedge clock_in) begin
    r <= next_r;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign apb_out.pready  = 1'b1;
  assign apb_out.pslverr = 1'b0;
  assign apb_out.prdata  = r.rdata;
  assign pad_out         = r.po;
  assign pad_oe_out      = r.poe;
  assign pad_pullup_out  = r.ppu;
  assign periph_in_out   = r.pin;
  assign sel_in_out      = r.sin;
  assign nmi_out         = {r.pin[NUM_PADS-1] & r.cfg[NUM_PADS-1].nmi, r.pin[NUM_PADS-2] & r.cfg[NUM_PADS-2].nmi};
  assign jtag_in_out     = {1'b0, r.pin[JTAG_TMS], r.pin[JTAG_TCK], r.pin[JTAG_TDI]};
  assign trace_data_out  = r.tdo;
  assign trace_data_oe_out = r.toe;
  assign trace_clock_out = trace_clk_in & r.toe[1];
  assign trace_msg_seq_out = trace_trace_msg_seq_out_in & r.toe[1];
  assign trace_port_oe_out = r.toe[1];
  assign supply_level_sel_out = r.supply;

endmodule : pfs_top

// >>> pfs_props.sv
// Checker: port-level properties of the pad function select block
`timescale 1ns/100ps
module pfs_props #(
  parameter int NUM_PADS = 16,
  parameter int NUM_SEL  = 4
) (
  input wire logic                  clock_in,             // Clock
  input wire logic                  rst_n_in,             // Reset
  input wire pfs_pkg::pfs_apb_req_t apb_in,               // Request
  input wire pfs_pkg::pfs_apb_rsp_t apb_out,              // Answer
  input wire logic [NUM_PADS-1:0]   pad_in,               // Pad level
  input wire logic [NUM_PADS-1:0]   pad_oe_out,           // Pad enables
  input wire logic [NUM_PADS-1:0]   periph_in_out,        // Gated inputs
  input wire logic [NUM_SEL-1:0]    sel_in_out,           // Shared inputs
  input wire logic [3:0]            jtag_in_out,          // Debug inputs
  input wire logic                  trace_clk_in,         // Clock source
  input wire logic                  trace_trace_msg_seq_out_in,        // Sequence source
  input wire logic                  trace_clock_out,      // Clock pad
  input wire logic                  trace_msg_seq_out,    // Sequence pad
  input wire logic                  trace_port_oe_out,    // Port enable
  input wire logic [11:0]           trace_data_oe_out,    // Data enables
  input wire logic [1:0]            supply_level_sel_out  // Supply bits
);
  import pfs_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic opt_wr;
  assign opt_wr = apb_in.psel && apb_in.penable && apb_in.pwrite && apb_in.paddr == PFS_OFF_USER_OPT;
  a_apb_answer: assert property (apb_in.psel && apb_in.penable |-> apb_out.pready && !apb_out.pslverr)
    else $error("access not answered at once");
  a_input_gated: assert property ((periph_in_out & ~$past(pad_in)) == '0)
    else $error("peripheral input without pad level");
  a_sel_source: assert property (|sel_in_out |-> |periph_in_out)
    else $error("shared input without a gated pad");
  a_jtag_spare: assert property (jtag_in_out[3] == 1'b0)
    else $error("spare debug input driven");
  a_supply_hold: assert property (!opt_wr |=> $stable(supply_level_sel_out))
    else $error("supply bits changed without a write");
  a_clk_gate: assert property (trace_clock_out |-> trace_clk_in && trace_port_oe_out)
    else $error("trace clock passed while disabled");
  a_seq_gate: assert property (trace_msg_seq_out |-> trace_trace_msg_seq_out_in && trace_port_oe_out)
    else $error("sequence pad passed while disabled");
  a_trace_upper: assert property (|trace_data_oe_out[11:8] |-> &trace_data_oe_out[7:1])
    else $error("upper trace pads without lower ones");
  a_pads_quiet: assert property ($rose(rst_n_in) |-> pad_oe_out == '0)
    else $error("pad driven on reset release");
endmodule : pfs_props

bind pfs_top pfs_props #(.NUM_PADS(NUM_PADS), .NUM_SEL(NUM_SEL)) u_props (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .apb_in(apb_in), .apb_out(apb_out),
  .pad_in(pad_in), .pad_oe_out(pad_oe_out), .periph_in_out(periph_in_out),
  .sel_in_out(sel_in_out), .jtag_in_out(jtag_in_out), .trace_clk_in(trace_clk_in),
  .trace_trace_msg_seq_out_in(trace_trace_msg_seq_out_in), .trace_clock_out(trace_clock_out),
  .trace_msg_seq_out(trace_msg_seq_out), .trace_port_oe_out(trace_port_oe_out),
  .trace_data_oe_out(trace_data_oe_out), .supply_level_sel_out(supply_level_sel_out));

// >>> pfs_pad_model.sv
// Pad model: board-side levels of the pads
`timescale 1ns/100ps
module pfs_pad_model #(
  parameter int NUM_PADS = 16
) (
  input  wire logic                clock_in,   // Clock
  input  wire logic [NUM_PADS-1:0] pad_out,    // Driven level
  input  wire logic [NUM_PADS-1:0] pad_oe_out, // Driven enable
  input  wire logic [NUM_PADS-1:0] pull_in,    // Weak pull-up
  input  wire logic [NUM_PADS-1:0] ext_in,     // Board level
  input  wire logic [NUM_PADS-1:0] ext_oe_in,  // Board drives
  output logic      [NUM_PADS-1:0] level_out   // Seen level
);
  logic flt;
  // Floating pads wander so no stale level passes
  always_ff @(posedge clock_in) flt <= (flt === 1'b1) ? 1'b0 : 1'b1;
  always_comb begin
    for (int i = 0; i < NUM_PADS; i++) begin
      if (pad_oe_out[i]) level_out[i] = pad_out[i];
      else if (ext_oe_in[i]) level_out[i] = ext_in[i];
      else if (pull_in[i]) level_out[i] = 1'b1;
      else level_out[i] = flt;
    end
  end
endmodule : pfs_pad_model

// >>> pfs_top_tb_top.sv
// Testbench: register-driven checks of the pad function select block
`timescale 1ns/100ps
`define CHK(a, b) check_count++; if ((a) !== (b)) begin fail_count++; $display("BAD t=%0t %h %h", $time, a, b); end
module pfs_top_tb_top;
  import pfs_pkg::*;
  logic clock_in = 1'b0, rst_n_in = 1'b0, memory_selftest_en_in = 1'b1, supply_ok_in = 1'b0;
  pfs_apb_req_t apb_in = '0;
  pfs_apb_rsp_t apb_out;
  logic [79:0] alt_out_in = '0;
  logic [15:0] gpio_out_in = '0;
  logic jtag_tdo_in = 1'b1;
  logic [15:0] ext_in = '0, ext_oe_in = '0, pad_in, pad_out, pad_oe_out, pull, periph_in_out;
  logic [3:0] sel_in_out;
  logic [1:0] nmi_out, supply_level_sel_out;
  logic [11:0] trace_data_out, trace_data_oe_out;
  logic [31:0] rd, rst_cfg [5] = '{32'h200, 32'h0, 32'h600, 32'h600, 32'h0};
  int fail_count = 0, check_count = 0, cyc = 0;
  always #4 clock_in = ~clock_in;
  pfs_top #(.SETTLE_CYC(4)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .apb_in(apb_in),
    .apb_out(apb_out), .alt_out_in(alt_out_in), .alt_oe_in('1), .gpio_out_in(gpio_out_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_out(pad_oe_out), .pad_pullup_out(pull), .periph_in_out(periph_in_out),
    .sel_in_out(sel_in_out), .nmi_out(nmi_out), .jtag_in_out(), .jtag_tdo_in(jtag_tdo_in),
    .memory_selftest_en_in(memory_selftest_en_in), .trace_data_in(12'ha5c), .trace_clk_in(1'b1), .trace_trace_msg_seq_out_in(1'b1),
    .trace_data_out(trace_data_out), .trace_data_oe_out(trace_data_oe_out), .trace_clock_out(),
    .trace_msg_seq_out(), .trace_port_oe_out(), .supply_level_sel_out(supply_level_sel_out),
    .supply_ok_in(supply_ok_in));
  pfs_pad_model pads (.clock_in(clock_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .pull_in(pull), .ext_in(ext_in), .ext_oe_in(ext_oe_in), .level_out(pad_in));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // Hang guard, well above the run length
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock_in);
    apb_in.penable <= 1'b1;
    do @(posedge clock_in); while (apb_out.pready !== 1'b1);
    rd = apb_out.prdata;
    apb_in <= '0;
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick
  initial begin
    tick(3);
    @(posedge clock_in) rst_n_in <= 1'b1;
    tick(2);
    `CHK(trace_data_out[0] & trace_data_oe_out[0], 1'b1)
    `CHK(pad_oe_out, 16'h0)
    apb(0, PFS_OFF_STATUS, 0);
    `CHK(rd[4:0], 5'h11)
    apb(1, PFS_OFF_DEV_PORT, 32'h5);
    supply_ok_in <= 1'b1;
    memory_selftest_en_in <= 1'b0;
    tick(10);
    apb(1, PFS_OFF_DEV_PORT, 32'h0);
    tick(2);
    `CHK(trace_data_oe_out, 12'hfff)
    `CHK(trace_data_out, 12'ha5c)
    `CHK(pull, 16'h000c)
    `CHK({pad_out[1], pad_oe_out[1]}, 2'b11)
    `CHK(supply_level_sel_out, 2'h3)
    for (int i = 0; i < 5; i++) begin
      apb(0, 12'(4 * i), 0);
      `CHK(rd, rst_cfg[i])
    end
    apb(1, 12'hffc, 32'hffffffff);
    apb(0, 12'hffc, 0);
    `CHK(rd, 32'h0)
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clock_in) alt_out_in <= (k < 5) ? (80'h1 << (25 + k)) : 80'h0;
      gpio_out_in <= (k >= 5) ? 16'h0020 : 16'h0000;
      apb(1, 12'h014, 32'h100 | k);
      tick(2);
      `CHK(pad_out[5], 1'(k != 0))
    end
    apb(1, 12'h004, 32'h100);
    tick(2);
    `CHK({pad_out[1], pad_oe_out[1]}, 2'b01)
    $display("test function done");
    @(posedge clock_in) ext_oe_in <= 16'h4040;
    ext_in <= 16'h4040;
    apb(1, 12'h018, 32'h3);
    tick(2);
    `CHK(periph_in_out[6], 1'b0)
    apb(1, 12'h018, 32'h200);
    apb(1, PFS_OFF_SRC_SEL_BASE, 32'h6);
    tick(2);
    `CHK({periph_in_out[6], sel_in_out[0]}, 2'b11)
    @(posedge clock_in) ext_in <= 16'h4000;
    apb(1, 12'h038, 32'h1301);
    tick(2);
    `CHK(sel_in_out[0], 1'b0)
    `CHK({nmi_out[0], pad_oe_out[14]}, 2'b10)
    apb(1, PFS_OFF_USER_OPT, 32'h1);
    tick(2);
    `CHK(supply_level_sel_out, 2'h1)
    @(posedge clock_in) rst_n_in <= 1'b0;
    tick(3);
    @(posedge clock_in) rst_n_in <= 1'b1;
    tick(3);
    `CHK(supply_level_sel_out, 2'h1)
    `CHK(trace_data_oe_out, 12'hfff)
    $display("test inputs done");
    stop_test();
  end
endmodule : pfs_top_tb_top
